/* File: hw/fault_timer.sv */
// Saturating event counter that flags when a terminal count is reached.
`timescale 1ns/10ps
module fault_timer #(
  parameter int unsigned LIMIT = 16
) (
  input  wire logic   sys_clk,
  input  wire logic   arst_n,
  fault_cnt_if.timer  ctl
);
  localparam int unsigned CW = fault_sup_pkg::CNT_W;
  localparam logic [CW-1:0] LIM = CW'(LIMIT);
  logic [fault_sup_pkg::CNT_W-1:0] cnt_q;
  logic [fault_sup_pkg::CNT_W-1:0] cnt_d;
  wire at_lim = (cnt_q >= LIM);

  assign cnt_d    = ctl.clear ? '0 : ((ctl.step && !at_lim) ? cnt_q + 1'b1 : cnt_q);
  assign ctl.done = at_lim;

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end
endmodule : fault_timer

/* File: hw/led_driver_fault_supervisor.sv */
// Fault supervision for a constant-current LED converter controller.
// Notes on behaviour
// - Any active fault releases at least one flag.
// - No fault: both flags actively pulled low.
// - Rail undervoltage: gate low, both flags released.
// - Undercurrent releases second flag, drive continues.
// - Overtemperature releases second flag, no drive limit.
// - Blank all detection except open and rail undervoltage after start.
// - Open string evaluated immediately, never blanked.
// - Open string: gate low, second flag released.
// - Open fault holds for timeout, then retries.
// - Compare string fraction and reference diode voltages.
// - Shorted LED releases second flag, unlatched.
// - Short faults clear after long enable low.
// - Open clears on enable low; output short only after the sleep delay.
// - Drive disabled only for hazardous faults.
// - Sleep delay counts 32768 oscillator periods.
// - Enable low beyond sleep delay enters sleep.
`timescale 1ns/10ps
module led_driver_fault_supervisor #(
  parameter int unsigned BLANK_CYC = fault_sup_pkg::START_BLANK_CYC,
  parameter int unsigned RETRY_CYC = fault_sup_pkg::OPEN_RETRY_CYC,
  parameter int unsigned SLEEP_OSC = fault_sup_pkg::SLEEP_OSC_PERIODS
) (
  input  wire logic sys_clk,
  input  wire logic arst_n,
  input  wire logic drive_enable,
  input  wire logic osc_tick,
  input  wire logic pwm_gate_req,
  input  wire logic rail_uv,
  input  wire logic undercurrent,
  input  wire logic overtemp,
  input  wire logic string_open,
  input  wire logic ref_diode_short,
  input  wire logic other_diode_short,
  input  wire logic string_short,
  input  wire logic output_short,
  output logic      gate_drive_out,
  output logic      fault_out_first_o,
  output logic      fault_out_first_oe,
  output logic      fault_out_second_o,
  output logic      fault_out_second_oe,
  output logic      sleep_mode
);
  fault_sup_pkg::run_state_t state_q;
  fault_sup_pkg::run_state_t state_d;
  logic open_lat_q;
  logic short_lat_q;
  logic first_rel_q;
  logic second_rel_q;
  logic gate_q;

  fault_cnt_if blank_if ();
  fault_cnt_if retry_if ();
  fault_cnt_if sleep_if ();

  fault_timer #(.LIMIT(BLANK_CYC)) u_blank (.sys_clk(sys_clk), .arst_n(arst_n), .ctl(blank_if.timer));
  fault_timer #(.LIMIT(RETRY_CYC)) u_retry (.sys_clk(sys_clk), .arst_n(arst_n), .ctl(retry_if.timer));
  fault_timer #(.LIMIT(SLEEP_OSC)) u_sleep (.sys_clk(sys_clk), .arst_n(arst_n), .ctl(sleep_if.timer));

  // The sleep delay follows the oscillator, so a slow oscillator lengthens it.
  assign sleep_if.clear = drive_enable;
  assign sleep_if.step  = !drive_enable && osc_tick;
  wire   sleep_reached  = sleep_if.done;

  wire in_sleep = (state_q == fault_sup_pkg::ST_SLEEP);
  wire in_blank = (state_q == fault_sup_pkg::ST_BLANK);
  wire in_run   = (state_q == fault_sup_pkg::ST_RUN);

  // Blanking restarts each time the converter leaves sleep or the rail recovers.
  assign blank_if.clear = in_sleep || rail_uv;
  assign blank_if.step  = in_blank;

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      fault_sup_pkg::ST_SLEEP: if (drive_enable && !rail_uv) state_d = fault_sup_pkg::ST_BLANK;
      fault_sup_pkg::ST_BLANK: if (blank_if.done) state_d = fault_sup_pkg::ST_RUN;
      fault_sup_pkg::ST_RUN:   if (rail_uv) state_d = fault_sup_pkg::ST_BLANK;
      default:                 state_d = fault_sup_pkg::ST_SLEEP;
    endcase
    if (sleep_reached) state_d = fault_sup_pkg::ST_SLEEP;
  end

  // Open string is taken in any awake state unless the rail is under voltage; the other detectors wait for blanking.
  wire open_det   = string_open && !in_sleep && !rail_uv;
  wire short_det  = in_run && (string_short || output_short);
  wire diode_sh   = in_run && (ref_diode_short || other_diode_short);
  wire ucur_det   = in_run && undercurrent;
  wire otemp_det  = in_run && overtemp;

  // Retry timer runs only while the open fault is held.
  assign retry_if.clear = !open_lat_q;
  assign retry_if.step  = open_lat_q;
  wire   retry_due      = open_lat_q && retry_if.done;

  // Set wins over clear; a held open retries and relatches if still present.
  wire open_lat_d  = open_det || (open_lat_q && !retry_due && drive_enable);
  wire short_lat_d = short_det || (short_lat_q && !sleep_reached);

  wire first_rel_d  = rail_uv || short_lat_d;
  wire second_rel_d = rail_uv || open_lat_d || ucur_det || otemp_det || diode_sh;
  wire hazard       = rail_uv || open_lat_d || short_lat_d;
  // Switching goes on during blanking, so the output can settle before it is judged.
  wire gate_d       = pwm_gate_req && drive_enable && !in_sleep && !hazard;

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q      <= fault_sup_pkg::ST_SLEEP;
      open_lat_q   <= 1'b0;
      short_lat_q  <= 1'b0;
      first_rel_q  <= 1'b0;
      second_rel_q <= 1'b0;
      gate_q       <= 1'b0;
    end else begin
      state_q      <= state_d;
      open_lat_q   <= open_lat_d;
      short_lat_q  <= short_lat_d;
      first_rel_q  <= first_rel_d;
      second_rel_q <= second_rel_d;
      gate_q       <= gate_d;
    end
  end

  // Open-drain flags: enable high pulls low, so a fault shows as release.
  assign fault_out_first_o   = 1'b0;
  assign fault_out_second_o  = 1'b0;
  assign fault_out_first_oe  = !first_rel_q;
  assign fault_out_second_oe = !second_rel_q;
  assign gate_drive_out      = gate_q;
  assign sleep_mode          = in_sleep;

  // Independent count of oscillator periods with the enable low, read only by the checks below.
  localparam int unsigned   CW        = fault_sup_pkg::CNT_W;
  localparam logic [CW-1:0] SLEEP_LIM = CW'(SLEEP_OSC);
  logic [CW-1:0]            tick_seen_q;
  logic [CW-1:0]            tick_seen_d;

  assign tick_seen_d = drive_enable ? '0 : ((osc_tick && (tick_seen_q < SLEEP_LIM)) ? tick_seen_q + 1'b1 : tick_seen_q);

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      tick_seen_q <= '0;
    end else begin
      tick_seen_q <= tick_seen_d;
    end
  end

  flags_release_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (rail_uv || (short_lat_q && !sleep_reached)) |=> !fault_out_first_oe) else $error("first flag not released");
  clean_pulls_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    !(rail_uv || open_lat_q || short_lat_q || ucur_det || otemp_det || diode_sh || open_det || short_det)
    |=> fault_out_second_oe && fault_out_first_oe) else $error("flag released without fault");
  uv_gate_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    rail_uv |=> !gate_drive_out && !fault_out_first_oe && !fault_out_second_oe) else $error("uv action wrong");
  ucur_flag_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    ucur_det |=> !fault_out_second_oe) else $error("undercurrent flag missing");
  otemp_flag_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    otemp_det |=> !fault_out_second_oe) else $error("overtemp flag missing");
  blank_hold_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (in_blank && !rail_uv && !open_det && !open_lat_q && !short_lat_q)
    |=> fault_out_first_oe && fault_out_second_oe) else $error("detection during blanking");
  open_now_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (string_open && in_blank && !rail_uv)
    |=> !gate_drive_out && !fault_out_second_oe) else $error("open not immediate");
  open_retry_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (retry_due && !string_open) |=> !open_lat_q) else $error("open retry missing");
  short_latch_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (short_lat_q && !sleep_reached) |=> short_lat_q && !gate_drive_out) else $error("short latch lost");
  sleep_enter_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (sleep_reached && !string_short && !output_short)
    |=> sleep_mode && !short_lat_q) else $error("sleep not entered");

  diode_flag_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    diode_sh
    |=> !fault_out_second_oe)
    else $error("shorted diode flag missing");
  diode_drive_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (diode_sh && pwm_gate_req && drive_enable && !rail_uv && !string_open && !open_lat_q
     && !short_lat_q && !string_short && !output_short)
    |=> gate_drive_out) else $error("drive stopped on shorted diode");
  ucur_drive_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (ucur_det && pwm_gate_req && drive_enable && !rail_uv && !string_open && !open_lat_q
     && !short_lat_q && !string_short && !output_short)
    |=> gate_drive_out) else $error("drive stopped on undercurrent");
  otemp_drive_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (otemp_det && pwm_gate_req && drive_enable && !rail_uv && !string_open && !open_lat_q
     && !short_lat_q && !string_short && !output_short)
    |=> gate_drive_out) else $error("drive limited on overtemperature");

  short_flag_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    short_det
    |=> !fault_out_first_oe && !gate_drive_out)
    else $error("short not acted on");
  short_second_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (short_lat_q && !sleep_reached && !rail_uv && !open_det && !open_lat_q && !ucur_det && !otemp_det && !diode_sh)
    |=> fault_out_second_oe)
    else $error("second flag released on short");
  open_clear_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (open_lat_q && !drive_enable && !string_open)
    |=> !open_lat_q)
    else $error("open latch kept with enable low");
  open_relatch_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (retry_due && string_open && !rail_uv && !in_sleep)
    |=> open_lat_q && !gate_drive_out)
    else $error("open not flagged again after retry");

  drive_keep_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (in_run && pwm_gate_req && drive_enable && !rail_uv && !string_open && !open_lat_q
     && !short_lat_q && !string_short && !output_short)
    |=> gate_drive_out) else $error("drive stopped without hazard");
  fault_mix_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (short_lat_q && !sleep_reached && ucur_det)
    |=> !fault_out_first_oe && !fault_out_second_oe && !gate_drive_out)
    else $error("combined faults not merged");

  sleep_early_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (tick_seen_q < SLEEP_LIM)
    |-> !sleep_reached)
    else $error("sleep delay ended early");
  sleep_late_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (tick_seen_q >= SLEEP_LIM)
    |-> sleep_reached)
    else $error("sleep delay ended late");

  open_cycle_c: cover property (@(posedge sys_clk) disable iff (!arst_n) retry_due ##1 open_lat_q);
  short_seen_c: cover property (@(posedge sys_clk) disable iff (!arst_n) short_det);
  sleep_seen_c: cover property (@(posedge sys_clk) disable iff (!arst_n) sleep_reached);
  blank_open_c: cover property (@(posedge sys_clk) disable iff (!arst_n) in_blank && open_det);
  uv_run_c:     cover property (@(posedge sys_clk) disable iff (!arst_n) in_run && rail_uv);
endmodule : led_driver_fault_supervisor

/* File: include/fault_cnt_if.sv */
// Interface carrying a timer's control and status between modules.
`timescale 1ns/10ps
interface fault_cnt_if;
  logic clear;
  logic step;
  logic done;
  modport owner (output clear, output step, input done);
  modport timer (input clear, input step, output done);
endinterface : fault_cnt_if

/* File: include/fault_sup_pkg.sv */
// Package with constants and state types for the LED fault supervisor.
package fault_sup_pkg;
  localparam int unsigned CLK_HZ             = 100_000_000;
  localparam int unsigned START_BLANK_US     = 1000;
  localparam int unsigned START_BLANK_CYC    = (CLK_HZ / 1_000_000) * START_BLANK_US;
  localparam int unsigned OPEN_RETRY_US      = 1000;
  localparam int unsigned OPEN_RETRY_CYC     = (CLK_HZ / 1_000_000) * OPEN_RETRY_US;
  localparam int unsigned SLEEP_OSC_PERIODS  = 32768;
  localparam int unsigned CNT_W              = 24;
  localparam logic [1:0]  OSC_DIV_RESET      = 2'h0;

  typedef enum logic [2:0] {
    ST_SLEEP = 3'b001,
    ST_BLANK = 3'b010,
    ST_RUN   = 3'b100
  } run_state_t;
endpackage : fault_sup_pkg

/* File: verif/flag_pullup_model.sv */
// Pull-up resistors on the two open-drain fault flags, as the board provides them.
`timescale 1ns/10ps
module flag_pullup_model (
  input  wire logic first_o,
  input  wire logic first_oe,
  input  wire logic second_o,
  input  wire logic second_oe,
  output logic      first_pin,
  output logic      second_pin
);
  // A released flag floats up through its resistor, so the pin reads high.
  assign first_pin  = first_oe ? first_o : 1'b1;
  assign second_pin = second_oe ? second_o : 1'b1;
endmodule : flag_pullup_model

/* File: verif/tb.sv */
// Self-checking bench for the LED fault supervisor.
`timescale 1ns/10ps
module tb;
  logic sys_clk = 1'b0, arst_n = 1'b0, drive_enable = 1'b0, osc_tick = 1'b0, pwm_gate_req = 1'b0;
  logic rail_uv = 1'b0, undercurrent = 1'b0, overtemp = 1'b0, string_open = 1'b0;
  logic ref_diode_short = 1'b0, other_diode_short = 1'b0, string_short = 1'b0, output_short = 1'b0;
  logic gate, f1_o, f1_oe, f2_o, f2_oe, sleep_mode, ff1, ff2;
  int   fail_count = 0;
  int   compares = 0;
  always #5 sys_clk = ~sys_clk;
  // A tick every other cycle keeps the sleep count short but real.
  always @(posedge sys_clk) osc_tick <= ~osc_tick;
  led_driver_fault_supervisor #(.BLANK_CYC(8), .RETRY_CYC(8), .SLEEP_OSC(4)) i_dut (
    .sys_clk(sys_clk), .arst_n(arst_n), .drive_enable(drive_enable), .osc_tick(osc_tick),
    .pwm_gate_req(pwm_gate_req), .rail_uv(rail_uv), .undercurrent(undercurrent), .overtemp(overtemp),
    .string_open(string_open), .ref_diode_short(ref_diode_short), .other_diode_short(other_diode_short),
    .string_short(string_short), .output_short(output_short), .gate_drive_out(gate),
    .fault_out_first_o(f1_o), .fault_out_first_oe(f1_oe), .fault_out_second_o(f2_o),
    .fault_out_second_oe(f2_oe), .sleep_mode(sleep_mode));
  flag_pullup_model i_pullups (.first_o(f1_o), .first_oe(f1_oe), .second_o(f2_o), .second_oe(f2_oe),
    .first_pin(ff1), .second_pin(ff2));
  task automatic step(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : step
  task automatic check(input logic seen, input logic exp);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic flags(input logic e1, input logic e2, input logic eg);
    check(ff1, e1);
    check(ff2, e2);
    check(gate, eg);
  endtask : flags
  task automatic t_blank();
    @(posedge sys_clk) {drive_enable, pwm_gate_req, undercurrent} <= 3'h7;
    step(3);
    check(ff2, 1'b0);
    @(posedge sys_clk) string_open <= 1'b1;
    step(1);
    flags(1'b0, 1'b1, 1'b0);
    @(posedge sys_clk) {string_open, undercurrent} <= 2'h0;
    step(20);
    flags(1'b0, 1'b0, 1'b1);
    $display("Test blank done");
  endtask : t_blank
  task automatic t_warn();
    for (int i = 0; i < 4; i++) begin
      @(posedge sys_clk) {undercurrent, overtemp, ref_diode_short, other_diode_short} <= 4'h8 >> i;
      step(1);
      flags(1'b0, 1'b1, 1'b1);
      @(posedge sys_clk) {undercurrent, overtemp, ref_diode_short, other_diode_short} <= 4'h0;
      step(1);
      flags(1'b0, 1'b0, 1'b1);
    end
    $display("Test warnings done");
  endtask : t_warn
  task automatic t_rail();
    @(posedge sys_clk) rail_uv <= 1'b1;
    step(1);
    flags(1'b1, 1'b1, 1'b0);
    @(posedge sys_clk) rail_uv <= 1'b0;
    step(2);
    flags(1'b0, 1'b0, 1'b1);
    $display("Test rail done");
  endtask : t_rail
  task automatic t_open();
    @(posedge sys_clk) string_open <= 1'b1;
    step(1);
    flags(1'b0, 1'b1, 1'b0);
    @(posedge sys_clk) string_open <= 1'b0;
    step(4);
    flags(1'b0, 1'b1, 1'b0);
    step(8);
    flags(1'b0, 1'b0, 1'b1);
    @(posedge sys_clk) string_open <= 1'b1;
    @(posedge sys_clk) {string_open, drive_enable} <= 2'h0;
    step(2);
    check(ff2, 1'b0);
    @(posedge sys_clk) drive_enable <= 1'b1;
    step(12);
    $display("Test open done");
  endtask : t_open
  task automatic t_short();
    @(posedge sys_clk) string_short <= 1'b1;
    @(posedge sys_clk) string_short <= 1'b0;
    step(4);
    flags(1'b1, 1'b0, 1'b0);
    @(posedge sys_clk) {output_short, undercurrent} <= 2'h3;
    step(1);
    flags(1'b1, 1'b1, 1'b0);
    @(posedge sys_clk) {output_short, undercurrent, drive_enable} <= 3'h0;
    @(posedge sys_clk) drive_enable <= 1'b1;
    step(3);
    flags(1'b1, 1'b0, 1'b0);
    @(posedge sys_clk) drive_enable <= 1'b0;
    step(12);
    check(sleep_mode, 1'b1);
    @(posedge sys_clk) drive_enable <= 1'b1;
    step(14);
    flags(1'b0, 1'b0, 1'b1);
    $display("Test short done");
  endtask : t_short
  task automatic give_verdict();
    $display("Counts: %0d compares, %0d mismatches", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : give_verdict
  initial begin
    repeat (3) @(posedge sys_clk);
    arst_n <= 1'b1;
    t_blank();
    t_warn();
    t_rail();
    t_open();
    t_short();
    give_verdict();
  end
  // The whole run needs about 125 cycles; this limit leaves ample room.
  initial begin
    #20us;
    fail_count++;
    give_verdict();
  end
endmodule : tb
